/* rtl/bififo_cfg_pkg.sv */
// constants, field layout and state types for the offset and mode loader
package bififo_cfg_pkg;

    // ------------------------------------------------------------------
    // offset register layout
    // ------------------------------------------------------------------
    // widths are those of the 1,024-deep part: 10-bit offsets, 40 serial bits
    localparam int OFFSET_W = 10;
    localparam int NUM_OFFSETS = 4;
    localparam int CFG_W = OFFSET_W * NUM_OFFSETS;
    // load order index: 0 fifo1 almost-full, 1 fifo1 almost-empty,
    // 2 fifo2 almost-full, 3 fifo2 almost-empty (packed msb to lsb)
    localparam logic [1:0] IDX_F1_AFULL = 2'h0;
    localparam logic [1:0] IDX_F1_AEMPTY = 2'h1;
    localparam logic [1:0] IDX_F2_AFULL = 2'h2;
    localparam logic [1:0] IDX_F2_AEMPTY = 2'h3;
    localparam logic [CFG_W-1:0] CFG_RESET = 40'h00_0000_0000;
    localparam logic [OFFSET_W-1:0] OFFSET_ZERO = 10'h000;

    // ------------------------------------------------------------------
    // preset offsets chosen by the flag-select pins
    // ------------------------------------------------------------------
    localparam logic [OFFSET_W-1:0] PRESET_64 = 10'h040;
    localparam logic [OFFSET_W-1:0] PRESET_16 = 10'h010;
    localparam logic [OFFSET_W-1:0] PRESET_8 = 10'h008;

    // ------------------------------------------------------------------
    // load sequencing
    // ------------------------------------------------------------------
    localparam int COUNT_W = 6;
    localparam logic [COUNT_W-1:0] COUNT_ZERO = 6'h00;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 6'h01;
    localparam logic [COUNT_W-1:0] PARALLEL_LAST = 6'h03;
    localparam logic [COUNT_W-1:0] SERIAL_LAST = 6'h27;

    // port clock edges before a space flag rises
    localparam int WAIT_W = 2;
    localparam logic [WAIT_W-1:0] WAIT_AFTER_RESET = 2'h2;
    localparam logic [WAIT_W-1:0] WAIT_AFTER_LOAD = 2'h1;
    localparam logic [WAIT_W-1:0] WAIT_NONE = 2'h0;
    localparam logic [WAIT_W-1:0] WAIT_STEP = 2'h1;

    // ------------------------------------------------------------------
    // port B bus size codes and lanes
    // ------------------------------------------------------------------
    localparam logic [1:0] BUS_LONG = 2'h0;
    localparam logic [1:0] BUS_WORD = 2'h1;
    localparam logic [1:0] BUS_BYTE = 2'h2;
    localparam logic [1:0] LANE_ZERO = 2'h0;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_PARALLEL,
        ST_SERIAL,
        ST_RUN
    } cfg_state_e;

endpackage

/* rtl/pin_filter.sv */
// three-stage pin synchroniser with agreement filter on the last two stages
`timescale 1ns/1ps

module pin_filter #(
    parameter int WIDTH = 1
) (
    input wire logic clk,                // core clock
    input wire logic nrst,               // synchronous reset, active low
    input wire logic [WIDTH-1:0] pin,    // raw asynchronous pins
    output logic [WIDTH-1:0] level       // filtered levels
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] check_reg;
    logic [WIDTH-1:0] level_reg;
    logic [WIDTH-1:0] level_next;

    // ------------------------------------------------------------------
    // filter
    // ------------------------------------------------------------------
    // a bit changes only when stages two and three agree; meta_reg is
    // read by sync_reg alone so a metastable value never reaches logic
    assign level_next = (sync_reg & check_reg) | (level_reg & (sync_reg | check_reg));
    assign level = level_reg;

    // three flops plus the filtered level
    always_ff @(posedge clk) begin
        if (!nrst) begin
            meta_reg <= '0;
            sync_reg <= '0;
            check_reg <= '0;
            level_reg <= '0;
        end else begin
            meta_reg <= pin;
            sync_reg <= meta_reg;
            check_reg <= sync_reg;
            level_reg <= level_next;
        end
    end

endmodule

/* rtl/bififo_config_and_offset_loader.sv */
// configuration capture and flag offset loader of the two-direction fifo
`timescale 1ns/1ps

module bififo_config_and_offset_loader
    import bififo_cfg_pkg::*;
(
    input wire logic clk,                                     // core clock, 250 MHz
    input wire logic nrst,                                    // sync reset, active low
    input wire logic fifo1_full_reset_n,                      // fifo1 master reset pin
    input wire logic fifo2_full_reset_n,                      // fifo2 master reset pin
    input wire logic order_timing_select,                     // byte order / timing pin
    input wire logic serial_prog_select_n,                    // serial-mode pin
    input wire logic flag_sel0_serial_in,                     // flag select 0 / serial data
    input wire logic flag_sel1_serial_en_n,                   // flag select 1 / serial enable
    input wire logic port_a_clock,                            // port A clock pin, sampled
    input wire logic port_b_clock,                            // port B clock pin, sampled
    input wire logic port_a_fifo1_write,                      // port A fifo1 write selected
    input wire logic [OFFSET_W-1:0] port_a_data_bus,          // low port A data pins
    input wire logic [1:0] port_b_bus_size,                   // port B size code
    input wire logic [1:0] port_b_part_index,                 // transfer number in long word
    output logic big_endian_select,                           // latched byte order
    output logic [1:0] port_b_lane,                           // long word lane in use
    output logic fifo1_fall_through_timing,                   // fifo1 timing mode
    output logic fifo2_fall_through_timing,                   // fifo2 timing mode
    output logic port_a_space_flag,                           // port A full / input ready
    output logic port_b_space_flag,                           // port B full / input ready
    output logic port_a_fifo1_store,                          // write goes to fifo1 memory
    output logic config_loading,                              // offset load in progress
    output logic [OFFSET_W-1:0] fifo1_almost_full_offset,     // port A almost-full offset
    output logic [OFFSET_W-1:0] fifo1_almost_empty_offset,    // port B almost-empty offset
    output logic [OFFSET_W-1:0] fifo2_almost_full_offset,     // port B almost-full offset
    output logic [OFFSET_W-1:0] fifo2_almost_empty_offset     // port A almost-empty offset
);

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------
    // bit position of an offset inside the packed register image
    function automatic int field_lsb(input logic [1:0] idx);
        return (NUM_OFFSETS - 1 - int'(idx)) * OFFSET_W;
    endfunction

    // replace one offset field of the packed image
    function automatic logic [CFG_W-1:0] put_field(input logic [CFG_W-1:0] img,
                                                   input logic [1:0] idx,
                                                   input logic [OFFSET_W-1:0] val);
        logic [CFG_W-1:0] res;
        res = img;
        res[field_lsb(idx) +: OFFSET_W] = val;
        return res;
    endfunction

    // preset offset for the flag-select code; 8 when only select 0 is high
    function automatic logic [OFFSET_W-1:0] preset_of(input logic fs1, input logic fs0);
        return (fs1 && fs0) ? PRESET_64 : (fs1 ? PRESET_16 : PRESET_8);
    endfunction

    // long word lane carried by a byte or word transfer
    function automatic logic [1:0] lane_of(input logic [1:0] size, input logic [1:0] idx,
                                           input logic msb_first);
        logic [1:0] part;
        part = msb_first ? ~idx : idx;
        return (size == BUS_BYTE) ? part : ((size == BUS_WORD) ? {1'b0, part[0]} : LANE_ZERO);
    endfunction

    // ------------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------------
    logic [OFFSET_W+8:0] pins_raw;
    logic [OFFSET_W+8:0] pins_f;
    logic fifo1_full_reset_n_low_f, fifo2_full_reset_n_low_f, fifo1_full_reset_n_f, fifo2_full_reset_n_f, sel_f, spm_n_f, fs0_f, fs1_f;
    logic port_a_clock_f, port_b_clock_f, wr_f;
    logic [OFFSET_W-1:0] data_f;

    assign pins_raw = {~fifo1_full_reset_n, ~fifo2_full_reset_n, order_timing_select,
                       serial_prog_select_n, flag_sel0_serial_in, flag_sel1_serial_en_n,
                       port_a_clock, port_b_clock, port_a_fifo1_write, port_a_data_bus};

    // data and port clock share one latency so data is seen with its edge
    pin_filter #(
        .WIDTH(OFFSET_W + 9)
    ) u_pins (
        .clk(clk),
        .nrst(nrst),
        .pin(pins_raw),
        .level(pins_f)
    );

    assign {fifo1_full_reset_n_low_f, fifo2_full_reset_n_low_f, sel_f, spm_n_f, fs0_f, fs1_f, port_a_clock_f, port_b_clock_f, wr_f,
            data_f} = pins_f;
    // master resets enter inverted so the cleared filter reads as released;
    // a core reset then never shows a false release edge
    assign fifo1_full_reset_n_f = ~fifo1_full_reset_n_low_f;
    assign fifo2_full_reset_n_f = ~fifo2_full_reset_n_low_f;

    // ------------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------------
    logic fifo1_full_reset_n_prev_reg, fifo2_full_reset_n_prev_reg, port_a_clock_prev_reg, port_b_clock_prev_reg;
    logic fifo1_full_reset_n_rise, fifo2_full_reset_n_rise, both_rise, port_a_clock_rise, port_b_clock_rise;

    // reset releases are caught in the same core cycle only if they arrive
    // within one filtered sample of each other
    assign fifo1_full_reset_n_rise = fifo1_full_reset_n_f & ~fifo1_full_reset_n_prev_reg;
    assign fifo2_full_reset_n_rise = fifo2_full_reset_n_f & ~fifo2_full_reset_n_prev_reg;
    assign both_rise = fifo1_full_reset_n_rise & fifo2_full_reset_n_rise;
    assign port_a_clock_rise = port_a_clock_f & ~port_a_clock_prev_reg;
    assign port_b_clock_rise = port_b_clock_f & ~port_b_clock_prev_reg;

    // previous filtered levels
    always_ff @(posedge clk) begin
        if (!nrst) begin
            fifo1_full_reset_n_prev_reg <= 1'b1; // released level, as the filter shows it
            fifo2_full_reset_n_prev_reg <= 1'b1;
            port_a_clock_prev_reg <= 1'b0;
            port_b_clock_prev_reg <= 1'b0;
        end else begin
            fifo1_full_reset_n_prev_reg <= fifo1_full_reset_n_f;
            fifo2_full_reset_n_prev_reg <= fifo2_full_reset_n_f;
            port_a_clock_prev_reg <= port_a_clock_f;
            port_b_clock_prev_reg <= port_b_clock_f;
        end
    end

    // ------------------------------------------------------------------
    // programming code decode at reset release
    // ------------------------------------------------------------------
    logic code_preset, code_parallel, code_serial;
    logic [OFFSET_W-1:0] preset_val;

    assign code_preset = spm_n_f & (fs0_f | fs1_f);
    assign code_parallel = spm_n_f & ~fs1_f & ~fs0_f;
    // serial-mode low with any other code is reserved and loads nothing
    assign code_serial = ~spm_n_f & fs1_f & ~fs0_f;
    assign preset_val = preset_of(fs1_f, fs0_f);

    // ------------------------------------------------------------------
    // load state machine
    // ------------------------------------------------------------------
    cfg_state_e state_reg, state_next;
    logic [COUNT_W-1:0] count_reg, count_next;
    logic [CFG_W-1:0] cfg_reg, cfg_next;
    logic par_write, ser_shift, par_done, ser_done;

    // a parallel load uses a fifo1 write that the space flag has admitted
    assign par_write = (state_reg == ST_PARALLEL) & port_a_clock_rise & wr_f & port_a_space_flag;
    // once in ST_RUN the enable pin no longer shifts anything
    assign ser_shift = (state_reg == ST_SERIAL) & port_a_clock_rise & ~fs1_f;
    assign par_done = par_write & (count_reg == PARALLEL_LAST);
    assign ser_done = ser_shift & (count_reg == SERIAL_LAST);

    // state and counter progression
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            ST_RESET: begin
                count_next = COUNT_ZERO;
                if (fifo1_full_reset_n_rise && code_parallel && both_rise) begin
                    state_next = ST_PARALLEL;
                end else if (fifo1_full_reset_n_rise && code_serial && both_rise) begin
                    state_next = ST_SERIAL;
                end else if (fifo1_full_reset_n_rise) begin
                    state_next = ST_RUN;
                end
            end
            ST_PARALLEL: begin
                if (par_done) begin
                    state_next = ST_RUN;
                end else if (par_write) begin
                    count_next = count_reg + COUNT_ONE;
                end
            end
            ST_SERIAL: begin
                if (ser_done) begin
                    state_next = ST_RUN;
                end else if (ser_shift) begin
                    count_next = count_reg + COUNT_ONE;
                end
            end
            ST_RUN: begin
                count_next = COUNT_ZERO;
            end
            default: begin
                state_next = ST_RESET;
                count_next = COUNT_ZERO;
            end
        endcase
        // fifo1 master reset low always restarts the sequence
        if (!fifo1_full_reset_n_f) begin
            state_next = ST_RESET;
            count_next = COUNT_ZERO;
        end
    end

    // offset image: fifo2 clear first, presets and loads override it
    always_comb begin
        cfg_next = cfg_reg;
        if (fifo2_full_reset_n_rise) begin
            cfg_next = put_field(cfg_next, IDX_F2_AFULL, OFFSET_ZERO);
            cfg_next = put_field(cfg_next, IDX_F2_AEMPTY, OFFSET_ZERO);
        end
        if (fifo1_full_reset_n_rise && code_preset) begin
            cfg_next = put_field(cfg_next, IDX_F1_AFULL, preset_val);
            cfg_next = put_field(cfg_next, IDX_F1_AEMPTY, preset_val);
            if (fifo2_full_reset_n_rise) begin
                cfg_next = put_field(cfg_next, IDX_F2_AFULL, preset_val);
                cfg_next = put_field(cfg_next, IDX_F2_AEMPTY, preset_val);
            end
        end
        if (par_write) begin
            cfg_next = put_field(cfg_reg, count_reg[1:0], data_f);
        end
        if (ser_shift) begin
            cfg_next = {cfg_reg[CFG_W-2:0], fs0_f};
        end
    end

    // state, counter and offset registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_reg <= ST_RESET;
            count_reg <= COUNT_ZERO;
            cfg_reg <= CFG_RESET;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            cfg_reg <= cfg_next;
        end
    end

    assign fifo1_almost_full_offset = cfg_reg[field_lsb(IDX_F1_AFULL) +: OFFSET_W];
    assign fifo1_almost_empty_offset = cfg_reg[field_lsb(IDX_F1_AEMPTY) +: OFFSET_W];
    assign fifo2_almost_full_offset = cfg_reg[field_lsb(IDX_F2_AFULL) +: OFFSET_W];
    assign fifo2_almost_empty_offset = cfg_reg[field_lsb(IDX_F2_AEMPTY) +: OFFSET_W];
    assign config_loading = (state_reg == ST_PARALLEL) | (state_reg == ST_SERIAL);

    // ------------------------------------------------------------------
    // space flags
    // ------------------------------------------------------------------
    logic [WAIT_W-1:0] wait_a_reg, wait_a_next, wait_b_reg, wait_b_next;
    logic space_a_reg, space_b_reg, space_a_next, space_b_next;

    // port A counts its own edges; serial load freezes it until done
    always_comb begin
        wait_a_next = wait_a_reg;
        if (fifo1_full_reset_n_rise) begin
            wait_a_next = WAIT_AFTER_RESET;
        end else if (ser_done) begin
            wait_a_next = WAIT_AFTER_LOAD;
        end else if (port_a_clock_rise && state_reg != ST_SERIAL && wait_a_reg != WAIT_NONE) begin
            wait_a_next = wait_a_reg - WAIT_STEP;
        end
    end

    // port B waits through the whole parallel or serial load
    always_comb begin
        wait_b_next = wait_b_reg;
        if (fifo2_full_reset_n_rise) begin
            wait_b_next = WAIT_AFTER_RESET;
        end else if (par_done || ser_done) begin
            wait_b_next = WAIT_AFTER_LOAD;
        end else if (port_b_clock_rise && !config_loading && wait_b_reg != WAIT_NONE) begin
            wait_b_next = wait_b_reg - WAIT_STEP;
        end
    end

    assign space_a_next = fifo1_full_reset_n_f & ~fifo1_full_reset_n_rise & (state_reg != ST_SERIAL) & ~ser_done &
                          (wait_a_next == WAIT_NONE);
    assign space_b_next = fifo2_full_reset_n_f & ~fifo2_full_reset_n_rise & ~config_loading & ~par_done & ~ser_done &
                          (wait_b_next == WAIT_NONE);

    // flag and wait registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wait_a_reg <= WAIT_AFTER_RESET;
            wait_b_reg <= WAIT_AFTER_RESET;
            space_a_reg <= 1'b0;
            space_b_reg <= 1'b0;
        end else begin
            wait_a_reg <= wait_a_next;
            wait_b_reg <= wait_b_next;
            space_a_reg <= space_a_next;
            space_b_reg <= space_b_next;
        end
    end

    // same flag serves as full flag in standard timing and input ready in
    // fall-through timing; only its meaning to the datapath differs
    assign port_a_space_flag = space_a_reg;
    assign port_b_space_flag = space_b_reg;

    // writes made during a parallel load never reach fifo1 memory
    assign port_a_fifo1_store = port_a_clock_rise & wr_f & space_a_reg & fifo1_full_reset_n_f &
                                (state_reg != ST_PARALLEL);

    // ------------------------------------------------------------------
    // byte order and timing mode capture
    // ------------------------------------------------------------------
    logic be_reg, pend1_reg, pend2_reg, fwft1_reg, fwft2_reg, msb_first;
    logic [1:0] lane_reg;

    // long words use every lane at once, so the order has no meaning
    assign msb_first = be_reg & (port_b_bus_size != BUS_LONG);

    // select pin is caught at the release, then again on the next port edge;
    // a later change of the pin is not watched, the host keeps it static
    always_ff @(posedge clk) begin
        if (!nrst) begin
            be_reg <= 1'b0;
            pend1_reg <= 1'b0;
            pend2_reg <= 1'b0;
            fwft1_reg <= 1'b0;
            fwft2_reg <= 1'b0;
            lane_reg <= LANE_ZERO;
        end else begin
            if (fifo1_full_reset_n_rise) begin
                be_reg <= sel_f;
                pend1_reg <= 1'b1;
            end else if (port_a_clock_rise && pend1_reg && fifo1_full_reset_n_f) begin
                pend1_reg <= 1'b0;
                fwft1_reg <= ~sel_f;
            end
            if (fifo2_full_reset_n_rise) begin
                pend2_reg <= 1'b1;
            end else if (port_b_clock_rise && pend2_reg && fifo2_full_reset_n_f) begin
                pend2_reg <= 1'b0;
                fwft2_reg <= ~sel_f;
            end
            lane_reg <= lane_of(port_b_bus_size, port_b_part_index, msb_first);
        end
    end

    assign big_endian_select = be_reg;
    assign port_b_lane = lane_reg;
    assign fifo1_fall_through_timing = fwft1_reg;
    assign fifo2_fall_through_timing = fwft2_reg;

endmodule

/* verification/loader_asserts.sv */
// port assertions for the offset and mode loader
`timescale 1ns/1ps
module loader_asserts
    import bififo_cfg_pkg::*;
(
    input wire logic clk, // core clock
    input wire logic nrst, // sync reset, active low
    input wire logic fifo1_full_reset_n, // fifo1 reset pin
    input wire logic [1:0] port_b_bus_size, // size code
    input wire logic [1:0] port_b_part_index, // part number
    input wire logic big_endian_select, // byte order
    input wire logic [1:0] port_b_lane, // lane in use
    input wire logic fifo1_fall_through_timing, // fifo1 mode
    input wire logic port_a_space_flag, // port A space
    input wire logic port_b_space_flag, // port B space
    input wire logic port_a_fifo1_store, // write to memory
    input wire logic config_loading // load active
);
    // the filter adds four cycles, so bounds leave room for it
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    mrs_space_a: assert property (!fifo1_full_reset_n [*8] |-> !port_a_space_flag)
        else $error("space flag a high in master reset");
    long_lane_a: assert property (port_b_bus_size == BUS_LONG |=> port_b_lane == LANE_ZERO)
        else $error("long word lane not zero");
    byte_lane_a: assert property (port_b_bus_size == BUS_BYTE |=> port_b_lane ==
        ($past(big_endian_select) ? ~$past(port_b_part_index) : $past(port_b_part_index)))
        else $error("byte lane order wrong");
    word_lane_a: assert property (port_b_bus_size == BUS_WORD |=> port_b_lane ==
        {1'b0, $past(port_b_part_index[0]) ^ $past(big_endian_select)})
        else $error("word lane order wrong");
    load_store_a: assert property (config_loading |-> !port_a_fifo1_store)
        else $error("offset write stored to memory");
    load_space_b_a: assert property (config_loading |-> !port_b_space_flag)
        else $error("space flag b high during load");
    done_space_a: assert property ($fell(config_loading) && fifo1_full_reset_n
        |-> ##[1:40] port_b_space_flag)
        else $error("space flag b late after load");
    mode_hold_a: assert property (port_a_space_flag && $past(port_a_space_flag)
        |-> $stable(fifo1_fall_through_timing))
        else $error("timing mode changed in operation");
    store_space_a: assert property (port_a_fifo1_store |-> port_a_space_flag)
        else $error("store while space flag low");
endmodule

bind bififo_config_and_offset_loader loader_asserts chk (.clk(clk), .nrst(nrst),
    .fifo1_full_reset_n(fifo1_full_reset_n), .port_b_bus_size(port_b_bus_size),
    .port_b_part_index(port_b_part_index), .big_endian_select(big_endian_select),
    .port_b_lane(port_b_lane), .fifo1_fall_through_timing(fifo1_fall_through_timing),
    .port_a_space_flag(port_a_space_flag), .port_b_space_flag(port_b_space_flag),
    .port_a_fifo1_store(port_a_fifo1_store), .config_loading(config_loading));

/* verification/port_hosts.sv */
// host model: free-running clocks of the two attached buses
`timescale 1ns/1ps
module port_hosts (
    input wire logic clk, // core clock
    output logic port_a_clock, // port A bus clock
    output logic port_b_clock // port B bus clock
);
    // non-blocking so a falling-edge reader never races the toggle;
    // unequal periods keep the ports from staying aligned
    initial begin
        port_a_clock = 1'b0;
        forever begin
            repeat (8) @(negedge clk);
            port_a_clock <= ~port_a_clock;
        end
    end
    initial begin
        port_b_clock = 1'b0;
        forever begin
            repeat (10) @(negedge clk);
            port_b_clock <= ~port_b_clock;
        end
    end
endmodule

/* verification/tb_top.sv */
// self-checking bench for the offset and mode loader
`timescale 1ns/1ps
module tb_top;
    import bififo_cfg_pkg::*;
    logic clk, nrst, fifo1_full_reset_n_n, fifo2_full_reset_n_n, ots, spm_n, fs0, fs1, wr, pa, pb;
    logic be, ft1, ft2, spa, spb, store, loading;
    logic [1:0] bsize, pidx, lane;
    logic [9:0] dat, y1, x1, y2, x2;
    logic [9:0] pre [3] = '{PRESET_64, PRESET_16, PRESET_8};
    logic [39:0] pv = {10'h3FC, 10'h001, 10'h155, 10'h0AA};
    logic [39:0] sv = {10'h155, 10'h2AA, 10'h0F0, 10'h30F};
    int n_fail = 0;
    int total_checks = 0;
    int n_store = 0;
    int i;
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // store pulses last one core cycle, so the falling edge inside it sees them
    always @(negedge clk) if (store === 1'b1) n_store++;
    bififo_config_and_offset_loader DUT (.clk(clk), .nrst(nrst), .fifo1_full_reset_n(fifo1_full_reset_n_n),
        .fifo2_full_reset_n(fifo2_full_reset_n_n), .order_timing_select(ots), .serial_prog_select_n(spm_n),
        .flag_sel0_serial_in(fs0), .flag_sel1_serial_en_n(fs1), .port_a_clock(pa),
        .port_b_clock(pb), .port_a_fifo1_write(wr), .port_a_data_bus(dat),
        .port_b_bus_size(bsize), .port_b_part_index(pidx), .big_endian_select(be),
        .port_b_lane(lane), .fifo1_fall_through_timing(ft1), .fifo2_fall_through_timing(ft2),
        .port_a_space_flag(spa), .port_b_space_flag(spb), .port_a_fifo1_store(store),
        .config_loading(loading), .fifo1_almost_full_offset(y1),
        .fifo1_almost_empty_offset(x1), .fifo2_almost_full_offset(y2),
        .fifo2_almost_empty_offset(x2));
    port_hosts host (.clk(clk), .port_a_clock(pa), .port_b_clock(pb));
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk_all(input logic [39:0] e);
        chk(y1, e[39:30]);
        chk(x1, e[29:20]);
        chk(y2, e[19:10]);
        chk(x2, e[9:0]);
    endtask
    // pulse one or both master resets; pins are held static afterwards
    task automatic mreset(input logic sel, sp, f1, f0, only2);
        {ots, spm_n, fs1, fs0} = {sel, sp, f1, f0};
        fifo2_full_reset_n_n = 1'b0;
        if (!only2) fifo1_full_reset_n_n = 1'b0;
        repeat (100) @(negedge clk);
        {fifo1_full_reset_n_n, fifo2_full_reset_n_n} = 2'b11;
    endtask
    // one port A rising edge seen, back on a falling core edge
    task automatic edge_a();
        int k;
        for (k = 0; k < 40 && pa !== 1'b0; k++) @(negedge clk);
        for (k = k; k < 40 && pa !== 1'b1; k++) @(negedge clk);
        if (k >= 40) begin
            n_fail++;
            summarize();
        end
    endtask
    task automatic wait_ready(input logic need_b);
        int k;
        for (k = 0; k < 300 && (spa !== 1'b1 || (need_b && spb !== 1'b1)); k++) @(negedge clk);
        if (k >= 300) begin
            n_fail++;
            summarize();
        end
    endtask
    initial begin
        nrst = 1'b0;
        {fifo1_full_reset_n_n, fifo2_full_reset_n_n, ots, spm_n, fs0, fs1, wr} = 7'h78;
        {dat, bsize, pidx} = '0;
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        // presets, byte order, timing mode and lanes for each code
        for (i = 0; i < 3; i++) begin
            mreset(i[0], 1'b1, i < 2, i != 1, 1'b0);
            wait_ready(1'b1);
            chk_all({4{pre[i]}});
            chk(be, i[0]);
            chk({ft1, ft2}, {2{~i[0]}});
            {bsize, pidx} = {BUS_BYTE, 2'h1};
            @(negedge clk);
            chk(lane, i[0] ? 2'h2 : 2'h1);
            bsize = BUS_WORD;
            @(negedge clk);
            chk(lane, {1'b0, ~i[0]});
            bsize = BUS_LONG;
            @(negedge clk);
            chk(lane, LANE_ZERO);
        end
        $display("preset test done");
        mreset(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
        wait_ready(1'b1);
        chk_all({PRESET_8, PRESET_8, 20'h0_0000});
        $display("fifo2 clear test done");
        mreset(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        wait_ready(1'b0);
        chk(spb, 1'b0);
        for (i = 0; i < 4; i++) begin
            dat = pv[39 - 10 * i -: 10];
            wr = 1'b1;
            edge_a();
        end
        wr = 1'b0;
        wait_ready(1'b1);
        chk_all(pv);
        chk(10'(n_store), 10'h000);
        // one ordinary write after the load must reach fifo1 memory once
        wr = 1'b1;
        edge_a();
        wr = 1'b0;
        repeat (6) @(negedge clk);
        chk(10'(n_store), 10'h001);
        $display("parallel test done");
        mreset(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        edge_a();
        edge_a();
        for (i = 39; i >= 0; i--) begin
            if (i == 0) chk({spa, spb}, 2'b00);
            {fs1, fs0} = {1'b0, sv[i]};
            edge_a();
        end
        fs0 = 1'b1;
        repeat (3) edge_a();
        fs1 = 1'b1;
        wait_ready(1'b1);
        chk_all(sv);
        $display("serial test done");
        summarize();
    end
endmodule
